// ===== verilog/dsp_supervisor.sv
// Watchdog and self-test supervisor for the on-board signal processor.
// Assumes service strobe, host test bit and status come from clk logic; pins are synced.
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_cfg.svh"
module dsp_supervisor #(
  parameter int WINDOW_CYC = `SVC_WINDOW_CYC,
  parameter int HOLD_CYC = `RST_HOLD_CYC,
  parameter int AW = `MEM_AW
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_sysreset_pin,
  input wire logic low_supply_pin,
  input wire logic service_wr,
  input wire logic test_start,
  input wire logic test_mode_disable,
  input wire logic led_off_wr,
  input wire logic fw_load_done,
  input wire logic [`NUM_REGIONS-1:0] fault_inject,
  output logic dsp_rst_q,
  output logic fw_load_q,
  output logic online_q,
  output logic test_busy_q,
  output logic test_done_q,
  output logic [`NUM_REGIONS-1:0] test_fail_q,
  output logic led_on_q,
  output logic test_disable_q,
  output logic wdog_event_q
);
  logic [1:0] bsr_sync_q, lsu_sync_q;
  logic bsr_q, lsu_q;
  supervisor_pkg::sup_state_e state_q, state_d;
  logic [31:0] wd_cnt_q;
  logic [15:0] hold_q;
  logic [AW-1:0] addr_q;
  logic [1:0] region_q;
  logic test_pend_q;
  logic [15:0] rdata0, rdata1, rdata2, rsel;
  logic [`NUM_REGIONS-1:0] fails_d;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  function automatic logic [15:0] pat(input logic [AW-1:0] a);
    pat = `TEST_PAT ^ 16'(a);
  endfunction

  always_ff @(posedge clk) begin
    // Pins from the backplane are asynchronous
    bsr_sync_q <= {bsr_sync_q[0], bus_sysreset_pin};
    lsu_sync_q <= {lsu_sync_q[0], low_supply_pin};
    bsr_q <= bsr_sync_q[1];
    lsu_q <= lsu_sync_q[1];
  end

  wire running = (state_q == supervisor_pkg::ST_RUN);
  wire wd_expire = running && !service_wr && (wd_cnt_q >= 32'(WINDOW_CYC - 1));
  wire rst_req = bsr_q || lsu_q || wd_expire;
  wire test_trig = bsr_q || wd_expire || (test_start && !test_mode_disable);
  wire last_addr = (addr_q == {AW{1'b1}});
  wire testing = (state_q == supervisor_pkg::ST_WRITE) || (state_q == supervisor_pkg::ST_READ)
    || (state_q == supervisor_pkg::ST_CHECK);
  wire ram_we = (state_q == supervisor_pkg::ST_WRITE);
  wire [15:0] wpat = pat(addr_q) ^ {15'h0000, fault_inject[region_q]};
  assign rsel = (region_q == 2'd0) ? rdata0 : (region_q == 2'd1) ? rdata1 : rdata2;
  wire mismatch = (rsel != pat(addr_q));

  // Only processor memories are exercised; field and host paths are not
  test_ram #(.AW(AW), .DW(16)) u_ctrl_mem (.clk(clk), .we(ram_we && region_q == 2'd0),
    .addr(addr_q), .wdata(wpat), .rdata(rdata0));
  test_ram #(.AW(AW), .DW(16)) u_log0_mem (.clk(clk), .we(ram_we && region_q == 2'd1),
    .addr(addr_q), .wdata(wpat), .rdata(rdata1));
  test_ram #(.AW(AW), .DW(16)) u_log1_mem (.clk(clk), .we(ram_we && region_q == 2'd2),
    .addr(addr_q), .wdata(wpat), .rdata(rdata2));

  always_comb begin
    state_d = state_q;
    case (state_q)
      supervisor_pkg::ST_RUN: begin
        if (rst_req) state_d = supervisor_pkg::ST_HOLD;
        else if (test_trig) state_d = supervisor_pkg::ST_WRITE;
      end
      supervisor_pkg::ST_HOLD: begin
        if (!bsr_q && !lsu_q && hold_q == 16'd0) state_d = supervisor_pkg::ST_LOAD;
      end
      supervisor_pkg::ST_LOAD: begin
        if (fw_load_done) state_d = test_pend_q ? supervisor_pkg::ST_WRITE
          : supervisor_pkg::ST_RUN;
      end
      supervisor_pkg::ST_WRITE: begin
        if (last_addr) state_d = supervisor_pkg::ST_READ;
      end
      supervisor_pkg::ST_READ: state_d = supervisor_pkg::ST_CHECK;
      supervisor_pkg::ST_CHECK: begin
        if (last_addr && region_q == 2'd2) state_d = supervisor_pkg::ST_POST;
        else if (last_addr) state_d = supervisor_pkg::ST_WRITE;
        else state_d = supervisor_pkg::ST_READ;
      end
      supervisor_pkg::ST_POST: state_d = supervisor_pkg::ST_RUN;
      default: state_d = supervisor_pkg::ST_RUN;
    endcase
    // Pin resets win in every state, even mid-test or mid-reload
    if (bsr_q || lsu_q) state_d = supervisor_pkg::ST_HOLD;
  end

  always_comb begin
    fails_d = test_fail_q;
    if (state_q == supervisor_pkg::ST_CHECK && mismatch) fails_d[region_q] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= supervisor_pkg::ST_HOLD;
      wd_cnt_q <= 32'd0;
      hold_q <= 16'(HOLD_CYC);
      addr_q <= '0;
      region_q <= 2'd0;
      test_pend_q <= 1'b1;
      dsp_rst_q <= 1'b1;
      fw_load_q <= 1'b0;
      online_q <= 1'b0;
      test_busy_q <= 1'b0;
      test_done_q <= 1'b0;
      test_fail_q <= '0;
      led_on_q <= 1'b1;
      test_disable_q <= 1'b0;
      wdog_event_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Restart on every service write; a late write cannot rescue an expired window
      wd_cnt_q <= (!running || service_wr) ? 32'd0 : wd_cnt_q + 32'd1;
      hold_q <= (state_q != supervisor_pkg::ST_HOLD) ? 16'(HOLD_CYC)
        : (hold_q != 16'd0) ? hold_q - 16'd1 : hold_q;
      if (state_q == supervisor_pkg::ST_HOLD && rst_req) hold_q <= 16'(HOLD_CYC);
      if (state_q == supervisor_pkg::ST_WRITE || state_q == supervisor_pkg::ST_CHECK) begin
        addr_q <= addr_q + 1'b1;
      end
      if (state_q == supervisor_pkg::ST_CHECK && last_addr) region_q <= region_q + 2'd1;
      if (state_q == supervisor_pkg::ST_POST) region_q <= 2'd0;
      // A run cut short by a pin reset must not resume mid-region
      if (state_d == supervisor_pkg::ST_WRITE && !testing) begin
        addr_q <= '0;
        region_q <= 2'd0;
      end
      if (rst_req) test_pend_q <= test_trig;
      else if (testing) test_pend_q <= 1'b0;
      dsp_rst_q <= (state_d == supervisor_pkg::ST_HOLD);
      fw_load_q <= (state_d == supervisor_pkg::ST_LOAD);
      online_q <= (state_d == supervisor_pkg::ST_RUN);
      test_busy_q <= (state_d == supervisor_pkg::ST_WRITE) || (state_d == supervisor_pkg::ST_READ)
        || (state_d == supervisor_pkg::ST_CHECK);
      test_fail_q <= fails_d;
      if (state_q == supervisor_pkg::ST_POST) test_done_q <= 1'b1;
      else if (state_d == supervisor_pkg::ST_WRITE && !testing) test_done_q <= 1'b0;
      if (state_d == supervisor_pkg::ST_WRITE && !testing) test_fail_q <= '0;
      // Host software decides health; the indicator lights on sys_rst and at the start of each self-test
      if (state_d == supervisor_pkg::ST_WRITE && !testing) led_on_q <= 1'b1;
      else if (led_off_wr) led_on_q <= 1'b0;
      test_disable_q <= test_mode_disable;
      wdog_event_q <= wd_expire;
    end
  end

  property p_wd_reset; wd_expire |=> dsp_rst_q && !online_q; endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("watchdog expiry did not reset processor");
  property p_supply; lsu_q |=> dsp_rst_q; endproperty
  a_supply: assert property (p_supply)
    else $error("low supply did not reset processor");
  property p_offline; (dsp_rst_q || fw_load_q) |-> !online_q; endproperty
  a_offline: assert property (p_offline)
    else $error("online during reset or reload");
  property p_reload; ($fell(dsp_rst_q) && !$past(sys_rst)) |-> fw_load_q; endproperty
  a_reload: assert property (p_reload)
    else $error("no firmware reload after reset");
  property p_count; (running && service_wr) |=> wd_cnt_q == 32'd0; endproperty
  a_count: assert property (p_count)
    else $error("service write did not restart count");
  property p_host_test;
    (running && !rst_req && test_start && !test_mode_disable) |=> test_busy_q;
  endproperty
  a_host_test: assert property (p_host_test)
    else $error("host test bit did not start self-test");
  property p_done;
    (state_q == supervisor_pkg::ST_POST && !bsr_q && !lsu_q) |=> test_done_q && online_q;
  endproperty
  a_done: assert property (p_done)
    else $error("test complete flag not set");
  property p_fail;
    (state_q == supervisor_pkg::ST_CHECK && mismatch) |=> test_fail_q[$past(region_q)];
  endproperty
  a_fail: assert property (p_fail)
    else $error("mismatch not posted");
  property p_wd_event; wd_expire |=> wdog_event_q; endproperty
  a_wd_event: assert property (p_wd_event)
    else $error("watchdog event not flagged");
  property p_bus_reset; bsr_q |=> dsp_rst_q && test_pend_q; endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("bus reset did not reset processor and queue self-test");
  property p_supply_quiet;
    (lsu_q && !bsr_q && !wd_expire && !(test_start && !test_mode_disable)) |=> !test_pend_q;
  endproperty
  a_supply_quiet: assert property (p_supply_quiet)
    else $error("low supply queued a self-test");
  property p_load_hold;
    (fw_load_q && !fw_load_done && !bsr_q && !lsu_q) |=> fw_load_q;
  endproperty
  a_load_hold: assert property (p_load_hold)
    else $error("reload ended before loader finished");
  property p_disable_blocks;
    (running && !rst_req && test_start && test_mode_disable) |=> online_q && !test_busy_q;
  endproperty
  a_disable_blocks: assert property (p_disable_blocks)
    else $error("disabled host test bit started self-test");
  property p_disable_copy; 1'b1 |=> test_disable_q == $past(test_mode_disable); endproperty
  a_disable_copy: assert property (p_disable_copy)
    else $error("test disable status wrong");
  property p_start_clear;
    $rose(test_busy_q) |-> led_on_q && !test_done_q && test_fail_q == '0;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("self-test start did not clear results");
  property p_count_grow;
    (running && !service_wr && !wd_expire) |=> wd_cnt_q == $past(wd_cnt_q) + 32'd1;
  endproperty
  a_count_grow: assert property (p_count_grow)
    else $error("watchdog count did not advance");
  c_expire: cover property (@(posedge clk) disable iff (sys_rst) wd_expire);
  c_done: cover property (@(posedge clk) disable iff (sys_rst) $rose(test_done_q));
  c_fail: cover property (@(posedge clk) disable iff (sys_rst) $rose(|test_fail_q));
endmodule
`default_nettype wire

// ===== verilog/supervisor_cfg.svh
// Constants for the signal-processor supervisor.
// Assumes a 50 MHz system clock.
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
`define CLK_HZ 50000000
`define SVC_WINDOW_US 1000
`define SVC_WINDOW_CYC ((`CLK_HZ / 1000000) * `SVC_WINDOW_US)
`define RST_HOLD_CYC 16
`define MEM_AW 4
`define NUM_REGIONS 3
`define RES_CTRL_BIT 0
`define RES_LOG0_BIT 1
`define RES_LOG1_BIT 2
`define TEST_PAT 16'hA55A
`endif

// ===== verilog/supervisor_pkg.sv
// Types for the signal-processor supervisor.
// Used with supervisor_cfg.svh.
package supervisor_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HOLD = 3'b001,
    ST_LOAD = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_CHECK = 3'b101,
    ST_POST = 3'b110
  } sup_state_e;
endpackage

// ===== verilog/test_ram.sv
// Small single-port RAM standing in for one memory region under test.
// Read data is registered; one cycle latency.
`timescale 1ns/100ps
`default_nettype none
module test_ram #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ===== test/dsp_model.sv
// Stand-in for the supervised processor and its firmware loader.
// Assumes the supervisor outputs are registers on clk.
`timescale 1ns/100ps
`default_nettype none
module dsp_model #(
  parameter int SVC_PERIOD = 12,
  parameter int LOAD_CYC = 5
) (
  input wire logic clk,
  input wire logic svc_en,
  input wire logic dsp_rst_q,
  input wire logic fw_load_q,
  output logic service_wr,
  output logic fw_load_done
);
  int svc_cnt = 0;
  int load_cnt = 0;
  initial begin
    service_wr = 1'b0;
    fw_load_done = 1'b0;
  end
  // Service inside the window; silent while held in reset
  always @(posedge clk) begin
    svc_cnt <= (dsp_rst_q || svc_cnt >= SVC_PERIOD) ? 0 : svc_cnt + 1;
    service_wr <= svc_en && !dsp_rst_q && svc_cnt == SVC_PERIOD;
  end
  // Reload takes a while, never finishes at once
  always @(posedge clk) begin
    load_cnt <= fw_load_q ? load_cnt + 1 : 0;
    fw_load_done <= fw_load_q && load_cnt == LOAD_CYC;
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the processor supervisor.
// Assumes short counts: window 20 cycles, hold 2 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int WIN = 20;
  logic clk = 0, sys_rst = 1, bus_rst = 0, low_sup = 0, svc_en = 1;
  logic start = 0, dis = 0, led_off = 0, service_wr, load_done;
  logic [2:0] fault = 3'h0, exp_fail = 3'h0;
  logic dsp_rst, fw_load, online, busy, done, done_prev = 0, led, dis_q, wdog;
  logic [2:0] fail;
  int mismatches = 0, n_compared = 0, seed = 93578, since_svc = 0;
  dsp_supervisor #(.WINDOW_CYC(WIN), .HOLD_CYC(2)) DUT (.clk(clk), .sys_rst(sys_rst),
    .bus_sysreset_pin(bus_rst), .low_supply_pin(low_sup), .service_wr(service_wr),
    .test_start(start), .test_mode_disable(dis), .led_off_wr(led_off),
    .fw_load_done(load_done), .fault_inject(fault), .dsp_rst_q(dsp_rst),
    .fw_load_q(fw_load), .online_q(online), .test_busy_q(busy), .test_done_q(done),
    .test_fail_q(fail), .led_on_q(led), .test_disable_q(dis_q), .wdog_event_q(wdog));
  dsp_model PROC (.clk(clk), .svc_en(svc_en), .dsp_rst_q(dsp_rst), .fw_load_q(fw_load),
    .service_wr(service_wr), .fw_load_done(load_done));
  initial forever #10 clk = ~clk;
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return online;
      1: return wdog;
      2: return fw_load;
      3: return busy;
      default: return dsp_rst;
    endcase
  endfunction
  // Bounded wait for a supervisor output to go high
  task automatic waitv(input int s);
    int n;
    n = 0;
    while (sig(s) !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(sig(s)), 8'h01);
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    case (s)
      0: start <= 1'b1;
      1: led_off <= 1'b1;
      2: low_sup <= 1'b1;
      default: bus_rst <= 1'b1;
    endcase
    @(posedge clk);
    {start, led_off, low_sup, bus_rst} <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Reference: watchdog age and per-region result at every test end
  always @(posedge clk) begin
    // Age restarts on a service write and whenever the board is not in normal run
    since_svc <= (service_wr || online !== 1'b1) ? 0 : since_svc + 1;
    done_prev <= done;
    if (wdog === 1'b1) chk(8'(!svc_en && since_svc == WIN), 8'h01);
    if (done === 1'b1 && done_prev !== 1'b1) chk(8'(fail), 8'(exp_fail));
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (9) @(posedge clk);
    #1;
    chk(8'({dsp_rst, online, led}), 8'h05);
    @(posedge clk);
    sys_rst <= 1'b0;
    waitv(2);
    waitv(3);
    waitv(0);
    chk(8'(done), 8'h01);
    pulse(1);
    chk(8'(led), 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      // At least one region always fails so the fail path is exercised
      fault <= 3'($random(seed)) | 3'h1;
      dis <= (i == 0);
      @(posedge clk);
      exp_fail <= fault;
      pulse(0);
      chk(8'({dis_q, busy, led}), (i == 0) ? 8'h04 : 8'h03);
      if (i == 1) waitv(0);
    end
    @(posedge clk);
    svc_en <= 1'b0;
    waitv(1);
    #20;
    chk(8'({dsp_rst, online}), 8'h02);
    waitv(2);
    waitv(3);
    svc_en <= 1'b1;
    waitv(0);
    // Low supply recovers through reload only
    pulse(2);
    waitv(4);
    waitv(2);
    waitv(0);
    chk(8'({busy, done}), 8'h01);
    pulse(3);
    waitv(4);
    waitv(3);
    waitv(0);
    // Let the result check on the rising complete flag run before ending
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
